// *** tma_pkg.sv ***
/*
 * constants, types and helper functions for the transmit message table
 * addressing block. assumes a single 125 MHz system clock domain.
 */
package tma_pkg;

    // ****************************************************************
    // sizes of the secondary register store
    // ****************************************************************
    localparam int unsigned TMA_LINES     = 16;    // data lines
    localparam int unsigned TMA_PER_LINE  = 16;    // registers per line
    localparam int unsigned TMA_SEC_TOTAL = 256;   // whole store

    // ****************************************************************
    // secondary register index within a line
    // ****************************************************************
    localparam logic [3:0] TMA_R_PRI_PTR  = 4'h0;  // tx_primary_pointer
    localparam logic [3:0] TMA_R_PRI_CNT  = 4'h1;  // tx_primary_count
    localparam logic [3:0] TMA_R_ALT_PTR  = 4'h2;  // tx_backup_pointer
    localparam logic [3:0] TMA_R_ALT_CNT  = 4'h3;  // tx_backup_count
    localparam logic [3:0] TMA_R_RX_PTR   = 4'h4;  // rx_pointer
    localparam logic [3:0] TMA_R_RX_CNT   = 4'h5;  // rx_count
    localparam logic [3:0] TMA_R_TX_BCC   = 4'h6;  // tx_block_check_sum
    localparam logic [3:0] TMA_R_RX_BCC   = 4'h7;  // rx_block_check_sum
    localparam logic [3:0] TMA_R_LINE_ST  = 4'hB;  // line state
    localparam logic [3:0] TMA_R_PROGRESS = 4'hC;  // line progress
    localparam logic [3:0] TMA_R_TX_MODE  = 4'hD;  // transmitter mode bits

    // ****************************************************************
    // host register select codes
    // ****************************************************************
    localparam logic [1:0] TMA_H_SCR    = 2'h0;    // system_control_reg
    localparam logic [1:0] TMA_H_STATUS = 2'h1;    // transfer_status_reg
    localparam logic [1:0] TMA_H_SELECT = 2'h2;    // secondary_select_reg
    localparam logic [1:0] TMA_H_ACCESS = 2'h3;    // secondary_access_reg

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int unsigned TMA_SCR_RUN    = 0;    // engine run flag
    localparam int unsigned TMA_SCR_EXT_LO = 4;    // address extension 04-05
    localparam int unsigned TMA_LS_TXRUN   = 6;    // transmitter run flag
    localparam int unsigned TMA_LS_ALT     = 7;    // alternate table in use
    localparam int unsigned TMA_PG_BCC     = 10;   // send block_check_char
    localparam int unsigned TMA_PG_MODE_LO = 13;   // new mode 13-15
    localparam int unsigned TMA_CNT_MARK   = 15;   // zero means marked
    localparam int unsigned TMA_ST_PEND    = 15;   // status pending
    localparam int unsigned TMA_ST_CODE_LO = 4;    // status code 6:4
    localparam logic [15:0] TMA_SCR_RESET  = 16'h0000;
    localparam logic [15:0] TMA_ST_RESET   = 16'h0000;
    localparam logic [2:0]  TMA_CODE_PRI   = 3'h1; // principal count zero
    localparam logic [2:0]  TMA_CODE_ALT   = 3'h2; // alternate count zero

    // ****************************************************************
    // engine states
    // ****************************************************************
    typedef enum logic [2:0] {
        TMA_IDLE, TMA_PTR, TMA_CNT, TMA_SWAP, TMA_MODE
    } tma_state_t;

    // low 15 bits count up and wrap, the mark bit rides along
    function automatic logic [15:0] tma_inc_cnt(input logic [15:0] c);
        tma_inc_cnt = {c[15], 15'(c[14:0] + 15'h0001)};
    endfunction

    // 18-bit character address step
    function automatic logic [17:0] tma_inc_addr(input logic [17:0] a);
        tma_inc_addr = 18'(a + 18'h0_0001);
    endfunction

endpackage

// *** tma_sec_if.sv ***
/*
 * carrier between the engine and the secondary register store.
 * assumes both ends run on sys_clk.
 */
`timescale 1ns/10ps
interface tma_sec_if;
    logic        host_we;      // host write strobe
    logic [7:0]  host_idx;     // host index {line, reg}
    logic [15:0] host_wdata;   // host write data
    logic [15:0] host_rdata;   // host read data
    logic        eng_we;       // engine write strobe
    logic [7:0]  eng_widx;     // engine write index
    logic [15:0] eng_wdata;    // engine write data
    logic [7:0]  eng_idx_b;    // engine read index b
    logic [7:0]  eng_idx_c;    // engine read index c
    logic [15:0] eng_rdata_b;  // engine read data b
    logic [15:0] eng_rdata_c;  // engine read data c

    modport engine (
        output host_we, host_idx, host_wdata, eng_we, eng_widx, eng_wdata, eng_idx_b, eng_idx_c,
        input  host_rdata, eng_rdata_b, eng_rdata_c
    );
    modport store (
        input  host_we, host_idx, host_wdata, eng_we, eng_widx, eng_wdata, eng_idx_b, eng_idx_c,
        output host_rdata, eng_rdata_b, eng_rdata_c
    );
endinterface

// *** tma_sec_store.sv ***
/*
 * secondary register store: 16 registers for each of 16 lines in flops.
 * a host write wins over an engine write to the same entry in one cycle.
 */
`timescale 1ns/10ps
module tma_sec_store
    import tma_pkg::*;
(
    input wire logic sys_clk,
    tma_sec_if.store sec
);

    // ****************************************************************
    // storage
    // ****************************************************************
    // 256 registers
    logic [15:0] mem_q [TMA_SEC_TOTAL];   // contents, volatile

    // no reset on purpose: initialize must not disturb contents
    // contents survive reset
    always_ff @(posedge sys_clk) begin
        if (sec.host_we) begin
            mem_q[sec.host_idx] <= sec.host_wdata;
        end
        // host wins a same-entry collision, software intent first
        if (sec.eng_we && !(sec.host_we && (sec.host_idx == sec.eng_widx))) begin
            mem_q[sec.eng_widx] <= sec.eng_wdata;
        end
    end

    // three combinational read ports
    assign sec.host_rdata  = mem_q[sec.host_idx];
    assign sec.eng_rdata_b = mem_q[sec.eng_idx_b];
    assign sec.eng_rdata_c = mem_q[sec.eng_idx_c];

endmodule

// *** tma_count_step.sv ***
/*
 * one step of the pointer and byte count for a transmitted character.
 * purely combinational; assumes the caller registers the results.
 */
`timescale 1ns/10ps
module tma_count_step
    import tma_pkg::*;
(
    input  wire logic [15:0] cnt_in,
    input  wire logic [15:0] ptr_in,
    input  wire logic [1:0]  ext_in,
    output logic      [15:0] cnt_out,
    output logic             cnt_zero,
    output logic      [17:0] addr_out
);

    // ****************************************************************
    // arithmetic
    // ****************************************************************
    // wrap and same-cycle zero
    assign cnt_out  = tma_inc_cnt(cnt_in);
    assign cnt_zero = (cnt_out[14:0] == 15'h0000);

    assign addr_out = tma_inc_addr({ext_in, ptr_in});

endmodule

// *** tma_tx_table.sv ***
/*
 * transmit message table addressing: host registers, engine that steps
 * pointer and count per character, table swap and mode change at zero.
 * assumes host port and transmitter strobes are on sys_clk.
 */
`timescale 1ns/10ps
module tma_tx_table
    import tma_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        bus_init,
    input  wire logic [1:0]  host_sel,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata_q,
    input  wire logic        tx_char_done,
    input  wire logic [3:0]  tx_line,
    output logic             tx_busy_q,
    output logic             mem_fetch_q,
    output logic      [17:0] mem_addr_q,
    output logic      [3:0]  event_line_q,
    output logic             tx_stop_q,
    output logic             mode_chg_q,
    output logic      [2:0]  new_mode_q,
    output logic             bcc_send_q
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    tma_sec_if   sec ();                 // store carrier
    logic [15:0] scr_q;                  // system_control_reg
    logic [15:0] stat_q;                 // transfer_status_reg
    logic [7:0]  sel_q;                  // secondary_select_reg {line, reg}
    logic [1:0]  ext_q [TMA_LINES];      // per-line address extension
    logic [15:0] mark_q;                 // per-line marked principal count, one bit a line
    tma_state_t  state_q;                // engine state
    tma_state_t  state_d;                // engine next state
    logic [3:0]  line_q;                 // line being served
    logic [15:0] ls_q;                   // latched line state
    logic [2:0]  mode_q;                 // pending new mode
    logic        use_alt;                // alternate table in use
    logic [3:0]  tab_ptr;                // pointer register index
    logic [3:0]  tab_cnt;                // count register index
    logic [15:0] cnt_next;               // stepped count
    logic        cnt_zero;               // stepped count is zero
    logic [17:0] addr_next;              // stepped address
    logic        start;                  // character accepted
    logic        acc_wr;                 // host write to access register
    logic        post;                   // status post this cycle
    logic [2:0]  post_code;              // status code to post

    assign use_alt = ls_q[TMA_LS_ALT];
    assign tab_ptr = use_alt ? TMA_R_ALT_PTR : TMA_R_PRI_PTR;
    assign tab_cnt = use_alt ? TMA_R_ALT_CNT : TMA_R_PRI_CNT;
    assign start   = tx_char_done && scr_q[TMA_SCR_RUN] && (state_q == TMA_IDLE);
    assign acc_wr  = host_wr && (host_sel == TMA_H_ACCESS);
    assign post    = (state_q == TMA_SWAP);
    assign post_code = use_alt ? TMA_CODE_ALT : TMA_CODE_PRI;

    // ****************************************************************
    // submodules
    // ****************************************************************
    tma_sec_store u_store (
        .sys_clk (sys_clk),
        .sec     (sec.store)
    );

    tma_count_step u_step (
        .cnt_in   (sec.eng_rdata_b),
        .ptr_in   (sec.eng_rdata_b),
        .ext_in   (ext_q[line_q]),
        .cnt_out  (cnt_next),
        .cnt_zero (cnt_zero),
        .addr_out (addr_next)
    );

    // ****************************************************************
    // host register access
    // ****************************************************************
    // indirect access through select
    assign sec.host_we    = acc_wr;
    assign sec.host_idx   = sel_q;
    assign sec.host_wdata = host_wdata;

    // control and select registers; initialize clears them, and status too unless a post lands in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scr_q <= TMA_SCR_RESET;
            sel_q <= 8'h00;
        end else if (bus_init) begin
            scr_q <= TMA_SCR_RESET;
            sel_q <= 8'h00;
        end else if (host_wr) begin
            if (host_sel == TMA_H_SCR) begin
                scr_q <= host_wdata;
            end
            if (host_sel == TMA_H_SELECT) begin
                sel_q <= host_wdata[7:0];
            end
        end
    end

    // status: a post wins over the read that clears it
    // post interrupt code
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= TMA_ST_RESET;
        end else if (post) begin
            stat_q <= {1'b1, 8'h00, post_code, line_q};
        end else if (bus_init) begin
            stat_q <= TMA_ST_RESET;
        end else if (host_rd && (host_sel == TMA_H_STATUS)) begin
            stat_q[TMA_ST_PEND] <= 1'b0;
        end
    end

    // read data register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_q <= 16'h0000;
        end else if (host_rd) begin
            case (host_sel)
                TMA_H_SCR:    host_rdata_q <= scr_q;
                TMA_H_STATUS: host_rdata_q <= stat_q;
                TMA_H_SELECT: host_rdata_q <= {8'h00, sel_q};
                default:      host_rdata_q <= sec.host_rdata;
            endcase
        end
    end

    // per-line extension and mark, caught at software load time
    // a limitation: not cleared by initialize, like the store itself
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < TMA_LINES; i++) begin
                ext_q[i]  <= 2'h0;
                mark_q[i] <= 1'b0;
            end
        end else begin
            if (acc_wr && (sel_q[3:0] == TMA_R_PRI_PTR)) begin
                ext_q[sel_q[7:4]] <= scr_q[TMA_SCR_EXT_LO +: 2];
            end else if ((state_q == TMA_PTR) && !use_alt) begin
                ext_q[line_q] <= addr_next[17:16];
            end
            if (acc_wr && (sel_q[3:0] == TMA_R_PRI_CNT)) begin
                mark_q[sel_q[7:4]] <= ~host_wdata[TMA_CNT_MARK];
            end
        end
    end

    // ****************************************************************
    // engine
    // ****************************************************************
    // next state and store port use
    always_comb begin
        state_d       = state_q;
        sec.eng_we    = 1'b0;
        sec.eng_widx  = {line_q, TMA_R_LINE_ST};
        sec.eng_wdata = 16'h0000;
        sec.eng_idx_b = {tx_line, TMA_R_LINE_ST};
        sec.eng_idx_c = {line_q, TMA_R_ALT_PTR};
        case (state_q)
            TMA_IDLE: begin
                if (start) begin
                    state_d = TMA_PTR;
                end
            end
            TMA_PTR: begin
                sec.eng_idx_b = {line_q, tab_ptr};
                sec.eng_we    = 1'b1;
                sec.eng_widx  = {line_q, tab_ptr};
                sec.eng_wdata = addr_next[15:0];
                state_d       = TMA_CNT;
            end
            TMA_CNT: begin
                sec.eng_idx_b = {line_q, tab_cnt};
                sec.eng_we    = 1'b1;
                sec.eng_widx  = {line_q, tab_cnt};
                sec.eng_wdata = cnt_next;
                state_d       = cnt_zero ? TMA_SWAP : TMA_IDLE;
            end
            TMA_SWAP: begin
                sec.eng_idx_b = {line_q, TMA_R_PROGRESS};
                if (!use_alt && ls_q[TMA_LS_TXRUN]) begin
                    sec.eng_we    = 1'b1;
                    sec.eng_wdata = ls_q | (16'h0001 << TMA_LS_ALT);
                end
                state_d = (!use_alt && mark_q[line_q]) ? TMA_MODE : TMA_IDLE;
            end
            TMA_MODE: begin
                sec.eng_idx_c = {line_q, TMA_R_TX_MODE};
                sec.eng_we    = 1'b1;
                sec.eng_widx  = {line_q, TMA_R_TX_MODE};
                sec.eng_wdata = {sec.eng_rdata_c[15:3], mode_q};
                state_d       = TMA_IDLE;
            end
            default: state_d = TMA_IDLE;
        endcase
    end

    // state and line context
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= TMA_IDLE;
            tx_busy_q <= 1'b0;
            line_q    <= 4'h0;
            ls_q      <= 16'h0000;
            mode_q    <= 3'h0;
        end else begin
            state_q   <= bus_init ? TMA_IDLE : state_d;
            tx_busy_q <= !bus_init && (state_d != TMA_IDLE);
            if (start) begin
                line_q <= tx_line;
                ls_q   <= sec.eng_rdata_b;
            end
            if (state_q == TMA_SWAP) begin
                mode_q <= sec.eng_rdata_b[TMA_PG_MODE_LO +: 3];
            end
        end
    end

    // one-cycle event outputs toward fetch and transmitter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_fetch_q  <= 1'b0;
            mem_addr_q   <= 18'h0_0000;
            event_line_q <= 4'h0;
            tx_stop_q    <= 1'b0;
            mode_chg_q   <= 1'b0;
            new_mode_q   <= 3'h0;
            bcc_send_q   <= 1'b0;
        end else begin
            mem_fetch_q <= 1'b0;
            tx_stop_q   <= 1'b0;
            mode_chg_q  <= 1'b0;
            bcc_send_q  <= 1'b0;
            if (state_q == TMA_PTR) begin
                mem_addr_q <= addr_next;
            end
            if ((state_q == TMA_CNT) && !cnt_zero) begin
                mem_fetch_q  <= 1'b1;
                event_line_q <= line_q;
            end
            if (state_q == TMA_SWAP) begin
                event_line_q <= line_q;
                if (!use_alt && ls_q[TMA_LS_TXRUN]) begin
                    mem_fetch_q <= 1'b1;
                    mem_addr_q  <= {ext_q[line_q], sec.eng_rdata_c};
                end else begin
                    tx_stop_q <= 1'b1;
                end
                bcc_send_q <= !use_alt && mark_q[line_q] && sec.eng_rdata_b[TMA_PG_BCC];
            end
            if (state_q == TMA_MODE) begin
                mode_chg_q <= 1'b1;
                new_mode_q <= mode_q;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_init_keeps_mark: assert property (bus_init && !host_wr |=> mark_q == $past(mark_q))
        else $error("mark flags changed on initialize");
    a_ext_load: assert property (acc_wr && sel_q[3:0] == TMA_R_PRI_PTR && !start && state_q == TMA_IDLE
        |=> ext_q[$past(sel_q[7:4])] == $past(scr_q[5:4]))
        else $error("extension not loaded from control bits");
    a_ptr_step: assert property (state_q == TMA_PTR |-> sec.eng_we && sec.eng_widx == {line_q, tab_ptr}
        ##1 mem_addr_q[15:0] == 16'($past(sec.eng_rdata_b) + 16'h0001))
        else $error("pointer not stepped by one");
    a_cnt_step: assert property (state_q == TMA_CNT |-> sec.eng_wdata[14:0] == 15'(sec.eng_rdata_b[14:0] + 15'h0001)
        && sec.eng_wdata[15] == sec.eng_rdata_b[15])
        else $error("count not stepped by one");
    a_zero_post: assert property (state_q == TMA_CNT && cnt_zero && !use_alt
        |=> ##1 stat_q[TMA_ST_PEND] && stat_q[6:4] == TMA_CODE_PRI)
        else $error("zero count not posted");
    a_alt_swap: assert property (state_q == TMA_SWAP && !use_alt && ls_q[TMA_LS_TXRUN]
        |-> sec.eng_we && sec.eng_wdata[TMA_LS_ALT] ##1 mem_fetch_q && !tx_stop_q)
        else $error("no swap to alternate table");
    a_mode_take: assert property (state_q == TMA_SWAP && !use_alt && mark_q[line_q]
        |=> state_q == TMA_MODE ##1 mode_chg_q && new_mode_q == $past(mode_q))
        else $error("marked count did not change mode");
    a_bcc_gate: assert property (state_q == TMA_SWAP && !(mark_q[line_q] && sec.eng_rdata_b[TMA_PG_BCC])
        |=> !bcc_send_q)
        else $error("check character sent without marked count");
    a_unmarked_keep: assert property (state_q == TMA_SWAP && !mark_q[line_q]
        |=> state_q != TMA_MODE ##1 !mode_chg_q)
        else $error("unmarked count changed mode");
    a_mark_load: assert property (acc_wr && sel_q[3:0] == TMA_R_PRI_CNT
        |=> mark_q[$past(sel_q[7:4])] == !$past(host_wdata[15]))
        else $error("mark not taken from load value");
    a_stop_line: assert property (state_q == TMA_SWAP && !(ls_q[TMA_LS_TXRUN] && !use_alt)
        |=> tx_stop_q && !mem_fetch_q)
        else $error("line not stopped at zero");
    a_zero_detect: assert property (state_q == TMA_CNT |=> ($past(cnt_zero) ? state_q == TMA_SWAP : mem_fetch_q)
        || $past(bus_init))
        else $error("zero not seen in count cycle");

    c_pri_swap:   cover property (state_q == TMA_SWAP && !use_alt && ls_q[TMA_LS_TXRUN]);
    c_mode_chg:   cover property (mode_chg_q && bcc_send_q == 1'b0 ##0 1'b1);
    c_line_stop:  cover property (tx_stop_q);
    c_plain_char: cover property (mem_fetch_q && !bcc_send_q);

endmodule

// *** tma_mem_model.sv ***
/* memory-side partner: logs character fetches.
   assumes fetch pulses last one sys_clk cycle. */
`timescale 1ns/10ps
module tma_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        mem_fetch_q,
    input  wire logic [17:0] mem_addr_q,
    output int               fetch_cnt
);
    // ****************
    // fetch log
    // ****************
    // data is not modelled, only how often memory is asked
    initial fetch_cnt = 0;
    always @(posedge sys_clk) begin
        if (mem_fetch_q === 1'b1) begin
            fetch_cnt <= fetch_cnt + 1;
        end
    end
endmodule

// *** testbench.sv ***
/* self-checking bench for the transmit table engine.
   assumes tma_pkg and the design files are compiled first. */
`timescale 1ns/10ps
module testbench;
    import tma_pkg::*;
    logic sys_clk = 0, rst_n = 0, bus_init = 0, host_wr = 0, host_rd = 0, tx_char_done = 0;
    logic [1:0]  host_sel = '0;   // host register select
    logic [15:0] host_wdata = '0; // host write data
    logic [3:0]  tx_line = '0;    // line of a sent character
    logic [15:0] host_rdata_q;   // read data
    logic        tx_busy_q, mem_fetch_q, tx_stop_q, mode_chg_q, bcc_send_q;
    logic [17:0] mem_addr_q;     // fetch address
    logic [3:0]  event_line_q;   // event line
    logic [2:0]  new_mode_q;     // new mode
    logic [3:0]  seen;           // {fetch, stop, mode, bcc} seen
    logic [17:0] f_addr;         // captured fetch address
    logic [2:0]  f_mode;         // captured mode
    int error_cnt = 0, cmp_count = 0, fetch_cnt;
    always #4 sys_clk = ~sys_clk;
    tma_tx_table uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_init(bus_init), .host_sel(host_sel),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_q(host_rdata_q),
        .tx_char_done(tx_char_done), .tx_line(tx_line), .tx_busy_q(tx_busy_q),
        .mem_fetch_q(mem_fetch_q), .mem_addr_q(mem_addr_q), .event_line_q(event_line_q),
        .tx_stop_q(tx_stop_q), .mode_chg_q(mode_chg_q), .new_mode_q(new_mode_q), .bcc_send_q(bcc_send_q));
    tma_mem_model mem (.sys_clk(sys_clk), .mem_fetch_q(mem_fetch_q), .mem_addr_q(mem_addr_q),
        .fetch_cnt(fetch_cnt));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        @(posedge sys_clk);
        host_sel <= s; host_wdata <= d; host_wr <= 1'b1;
        @(posedge sys_clk);
        host_wr <= 1'b0;
    endtask
    // secondary write: select then access
    task automatic swr(input logic [7:0] i, input logic [15:0] d);
        wr(TMA_H_SELECT, {8'h00, i}); wr(TMA_H_ACCESS, d);
    endtask
    task automatic rd(input logic [1:0] s, input logic [15:0] exp, input string what);
        @(posedge sys_clk);
        host_sel <= s; host_rd <= 1'b1;
        @(posedge sys_clk);
        host_rd <= 1'b0;
        @(posedge sys_clk) #1;
        chk({2'b00, host_rdata_q}, {2'b00, exp}, what);
    endtask
    // one sent character; bounded watch of the engine pulses
    task automatic char_evt(input logic [3:0] l);
        seen = 4'h0;
        @(posedge sys_clk);
        tx_line <= l; tx_char_done <= 1'b1;
        @(posedge sys_clk);
        tx_char_done <= 1'b0;
        repeat (8) begin
            @(posedge sys_clk) #1;
            if (mem_fetch_q === 1'b1) begin
                seen[3] = 1'b1; f_addr = mem_addr_q;
            end
            if (tx_stop_q === 1'b1) seen[2] = 1'b1;
            if (mode_chg_q === 1'b1) begin
                seen[1] = 1'b1; f_mode = new_mode_q;
            end
            if (bcc_send_q === 1'b1) seen[0] = 1'b1;
        end
        if (seen[3:2] == 2'b00 || tx_busy_q !== 1'b0) begin
            error_cnt++;
            $display("ERROR engine answer expected pulse seen none");
            end_sim();
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic sc_load_line3();
        wr(TMA_H_SCR, 16'h0010); swr(8'h30, 16'h1234);
        swr(8'h31, 16'hFFFE); swr(8'h32, 16'h0100);
        swr(8'h33, 16'hFFFF); swr(8'h3B, 16'h0040);
        swr(8'h50, 16'h2000); swr(8'h5D, 16'h0000);
        swr(8'h51, 16'h7FFF); swr(8'h5B, 16'h0000); swr(8'h5C, 16'hA400);
        @(posedge sys_clk) bus_init <= 1'b1;
        @(posedge sys_clk) bus_init <= 1'b0;
        wr(TMA_H_SELECT, 16'h0031); rd(TMA_H_ACCESS, 16'hFFFE, "count kept");
        wr(TMA_H_SCR, 16'h0011);
    endtask
    task automatic sc_line3_swap();
        char_evt(4'h3); chk(f_addr, 18'h1_1235, "first fetch");
        chk({14'h0, event_line_q}, 18'h3, "event line");
        wr(TMA_H_SELECT, 16'h0031); rd(TMA_H_ACCESS, 16'hFFFF, "count step");
        char_evt(4'h3); chk({2'b00, f_addr[15:0]}, 18'h0100, "alt fetch");
        chk({14'h0, seen}, 18'h8, "unmarked pulses");
        rd(TMA_H_ACCESS, 16'h8000, "count wrap");
        rd(TMA_H_STATUS, 16'h8013, "zero status");
        wr(TMA_H_SELECT, 16'h003B); rd(TMA_H_ACCESS, 16'h00C0, "alt in use");
        // alternate count of all ones ends after one more character
        char_evt(4'h3); chk({14'h0, seen}, 18'h4, "alt zero pulses");
        chk(mem_addr_q, 18'h1_0101, "alt pointer step");
        rd(TMA_H_STATUS, 16'h8023, "alt status");
    endtask
    task automatic sc_line5_marked();
        char_evt(4'h5); chk({14'h0, seen}, 18'h7, "marked pulses");
        chk({15'h0, f_mode}, 18'h5, "new mode");
        rd(TMA_H_STATUS, 16'h8015, "marked status");
        chk(18'(fetch_cnt), 18'h2, "fetch total");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        sc_load_line3();
        sc_line3_swap();
        sc_line5_marked();
        end_sim();
    end
endmodule
